// file: hw/ulms_core.sv
// line status, modem status, scratch and divisor registers of one channel
`timescale 1ns/1ps
module ulms_core
  import ulms_pkg::*;
#(
  parameter int RXF_DEPTH = 128,
  parameter int PTR_W     = $clog2(RXF_DEPTH)
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // host register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  // serial engine status
  input  wire logic             fifo_mode,
  input  wire logic             shift_load,
  input  wire logic             shifter_busy,
  input  wire logic             txf_empty,
  input  wire logic             rxf_push,
  input  wire logic [2:0]       rxf_push_tags,
  input  wire logic             rxf_pop,
  input  wire logic             rxf_clear,
  // modem pins, active low
  input  wire logic             cts_n,
  input  wire logic             dsr_n,
  input  wire logic             ring_n,
  input  wire logic             cd_n,
  // outputs
  output logic                  holding_wr,
  output logic                  modem_irq,
  output logic      [15:0]      divisor,
  output logic                  loopback
);
  typedef struct packed {
    logic [3:0]       delta;
    logic             thr_empty;
    logic [7:0]       lctl;
    logic [7:0]       mctl;
    logic [7:0]       interrupt_enable;
    logic [7:0]       scr;
    logic [7:0]       dll;
    logic [7:0]       divisor_high_byte;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0]   err_cnt;
    logic [7:0]       rdata;
    logic             hwr;
    logic             irq;
  } ulms_state_t;

  ulms_state_t          st_r, st_nxt;
  logic [RXF_DEPTH-1:0] err_mem_r;
  logic [3:0]           pins_n;
  logic [3:0]           pin_lvl;
  logic [3:0]           pin_chg;
  logic [3:0]           msr_lvl;
  logic                 dl_sel;
  logic                 loop_on;
  logic                 ms_read;
  logic                 err_in;
  logic                 err_out;
  logic                 thr_flag;
  logic                 tx_empty_all;
  logic [7:0]           lstat_val;
  logic [7:0]           mstat_val;

  assign pins_n  = {cd_n, ring_n, dsr_n, cts_n};
  assign dl_sel  = st_r.lctl[LCTL_DIV_BIT];
  assign loop_on = st_r.mctl[MCTL_LOOP_BIT];
  assign ms_read = reg_rd && (reg_addr == ADDR_MSTAT);
  assign err_in  = rxf_push & (|rxf_push_tags);
  assign err_out = rxf_pop & err_mem_r[st_r.rp];

  // one watcher per pin; only the ring input counts rising edges alone
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    ulms_pin_watch #(
      .IDLE_LVL  (PIN_IDLE[i]),
      .RISE_ONLY (i == PIN_RING)
    )
    u_ulms_pin_watch
    (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin_n   (pins_n[i]),
      .lvl     (pin_lvl[i]),
      .changed (pin_chg[i])
    );
  end

  // order: cts, dsr, ring, cd; loopback ignores the pins entirely
  always_comb
  begin
    if (loop_on)
    begin
      msr_lvl[0] = st_r.mctl[MCTL_RTS_BIT];
      msr_lvl[1] = st_r.mctl[MCTL_DTR_BIT];
      msr_lvl[2] = st_r.mctl[MCTL_OUT1_BIT];
      msr_lvl[3] = st_r.mctl[MCTL_OUT2_BIT];
    end
    else
    begin
      msr_lvl[0] = ~pin_lvl[0];
      msr_lvl[1] = ~pin_lvl[1];
      msr_lvl[2] = ~pin_lvl[2];
      msr_lvl[3] = ~pin_lvl[3];
    end
  end

  // a busy shifter keeps the fully-empty flag low in either mode
  assign thr_flag     = fifo_mode ? txf_empty : st_r.thr_empty;
  assign tx_empty_all = thr_flag & ~shifter_busy;
  assign lstat_val    = {(st_r.err_cnt != '0), tx_empty_all, thr_flag, 5'h00};
  assign mstat_val    = {msr_lvl, st_r.delta};

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.hwr = 1'b0;
    // read clears first so a change in the same cycle still lands
    if (ms_read)
    begin
      st_nxt.delta = 4'h0;
    end
    // pin changes are ignored while looped back; the pins stay isolated
    if (!loop_on)
    begin
      st_nxt.delta = st_nxt.delta | pin_chg;
    end
    // load to shifter sets, host write clears in same cycle
    if (shift_load)
    begin
      st_nxt.thr_empty = 1'b1;
    end
    // receive error tag store, one bit per entry
    if (rxf_clear)
    begin
      st_nxt.wp      = '0;
      st_nxt.rp      = '0;
      st_nxt.err_cnt = '0;
    end
    else
    begin
      if (rxf_push)
      begin
        st_nxt.wp = st_r.wp + 1'b1;
      end
      if (rxf_pop)
      begin
        st_nxt.rp = st_r.rp + 1'b1;
      end
      if (err_in && !err_out)
      begin
        st_nxt.err_cnt = st_r.err_cnt + 1'b1;
      end
      else if (err_out && !err_in)
      begin
        st_nxt.err_cnt = st_r.err_cnt - 1'b1;
      end
    end
    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_DATA:
        begin
          if (dl_sel)
          begin
            st_nxt.dll = reg_wdata;
          end
          else
          begin
            st_nxt.hwr       = 1'b1;
            st_nxt.thr_empty = 1'b0;
          end
        end
        ADDR_IER:
        begin
          if (dl_sel)
          begin
            st_nxt.divisor_high_byte = reg_wdata;
          end
          else
          begin
            st_nxt.interrupt_enable = reg_wdata;
          end
        end
        ADDR_LCTL:
        begin
          st_nxt.lctl = reg_wdata;
        end
        ADDR_MCTL:
        begin
          // unused control bits read back as zero
          st_nxt.mctl = {3'h0, reg_wdata[4:0]};
        end
        ADDR_SCR:
        begin
          st_nxt.scr = reg_wdata;
        end
        default:
        begin
          // status registers are read-only; writes are dropped
          st_nxt.scr = st_r.scr;
        end
      endcase
    end
    // the read mux runs every cycle; only the modem status read has a side effect
    case (reg_addr)
      ADDR_DATA:
      begin
        // receive path lives elsewhere, so the data port reads zero unless the divisor access bit selects the low divisor byte
        st_nxt.rdata = dl_sel ? st_r.dll : REG_RESET;
      end
      ADDR_IER:
      begin
        st_nxt.rdata = dl_sel ? st_r.divisor_high_byte : st_r.interrupt_enable;
      end
      ADDR_LCTL:
      begin
        st_nxt.rdata = st_r.lctl;
      end
      ADDR_MCTL:
      begin
        st_nxt.rdata = st_r.mctl;
      end
      ADDR_LSTAT:
      begin
        st_nxt.rdata = lstat_val;
      end
      ADDR_MSTAT:
      begin
        st_nxt.rdata = mstat_val;
      end
      ADDR_SCR:
      begin
        st_nxt.rdata = st_r.scr;
      end
      default:
      begin
        st_nxt.rdata = REG_RESET;
      end
    endcase
    // any change flag raises the line while the enable bit is set
    if ((|st_nxt.delta) && st_nxt.interrupt_enable[IER_MS_BIT])
    begin
      st_nxt.irq = 1'b1;
    end
    else
    begin
      st_nxt.irq = 1'b0;
    end
    if (!rst_n)
    begin
      st_nxt           = '0;
      st_nxt.thr_empty = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
    // tag memory needs no reset: the counter says what is valid
    if (rxf_push && !rxf_clear)
    begin
      err_mem_r[st_r.wp] <= err_in;
    end
  end

  assign reg_rdata  = st_r.rdata;
  assign holding_wr = st_r.hwr;
  assign modem_irq  = st_r.irq;
  assign divisor    = {st_r.divisor_high_byte, st_r.dll};
  assign loopback   = st_r.mctl[MCTL_LOOP_BIT];
endmodule

// one modem pin: three-stage synchroniser and change detector
module ulms_pin_watch
  import ulms_pkg::*;
#(
  parameter logic IDLE_LVL  = 1'b1,
  parameter bit   RISE_ONLY = 1'b0
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pin, active low
  input  wire logic pin_n,
  // filtered level and change strobe
  output logic      lvl,
  output logic      changed
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ulms_pin_t;

  ulms_pin_t st_r, st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    // only the second stage reads the first; the third just confirms
    st_nxt.s1 = pin_n;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a level counts once two stages agree, so a one-cycle glitch is lost
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.lvl = st_r.s3;
    end
    if (!rst_n)
    begin
      // idle level at reset keeps a false edge out after release
      st_nxt = {4{IDLE_LVL}};
    end
  end

  always_comb
  begin
    if (RISE_ONLY)
    begin
      // low to high on the pin only, which is the end of a ring
      changed = st_nxt.lvl & ~st_r.lvl;
    end
    else
    begin
      changed = st_nxt.lvl ^ st_r.lvl;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  assign lvl = st_r.lvl;
endmodule

// file: hw/ulms_pkg.sv
// constants for the line and modem status block
// How it works
// - non-fifo: empty set on shift load, cleared on write
// - fifo mode: empty flag follows tx fifo empty
// - fully-empty set when idle, clear if loaded
// - fifo mode: fifo and shifter both empty
// - error summary while any stored byte tagged
// - cts/dsr/cd change flags since last read
// - ring change flag only when ring ends
// - modem interrupt when change flag and enabled
// - cts bit: inverted pin, or rts in loopback
// - dsr bit: inverted pin, or dtr in loopback
// - ring bit: inverted pin, or control bit 2
// - cd bit: inverted pin, or control bit 3
// - 8-bit scratch register, no side effects
// - divisor is high byte over low byte
// - divisor access bit maps divisor bytes
// - control bit 4 selects internal loopback
// - per-character error tag: any of the three tags sets its one bit
package ulms_pkg;
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_IER    = 3'h1;
  localparam logic [2:0] ADDR_LCTL   = 3'h3;
  localparam logic [2:0] ADDR_MCTL   = 3'h4;
  localparam logic [2:0] ADDR_LSTAT  = 3'h5;
  localparam logic [2:0] ADDR_MSTAT  = 3'h6;
  localparam logic [2:0] ADDR_SCR    = 3'h7;
  localparam int LCTL_DIV_BIT  = 7;
  localparam int MCTL_DTR_BIT  = 0;
  localparam int MCTL_RTS_BIT  = 1;
  localparam int MCTL_OUT1_BIT = 2;
  localparam int MCTL_OUT2_BIT = 3;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int IER_MS_BIT    = 3;
  localparam int PIN_RING      = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] PIN_IDLE  = 4'hF;
endpackage

// file: verification/ulms_modem.sv
// modem equipment model driving the active-low status pins
`timescale 1ns/1ps
module ulms_modem
(
  // wanted levels, active high {cd,ring,dsr,cts}
  input  wire logic [3:0] lvl,
  // pins, active low
  output wire logic       cts_n,
  output wire logic       dsr_n,
  output wire logic       ring_n,
  output wire logic       cd_n
);
  // pins move off the clock edge, as a real modem's would
  assign #3 {cd_n, ring_n, dsr_n, cts_n} = ~lvl;
endmodule

// file: verification/ulms_core_props.sv
// assertions on the register port of the status block
`timescale 1ns/1ps
module ulms_core_props
  import ulms_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [2:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        fifo_mode,
  input wire logic        txf_empty,
  input wire logic        holding_wr,
  input wire logic        modem_irq,
  input wire logic [15:0] divisor,
  input wire logic        loopback
);
  logic       dl_r;
  logic [7:0] sp_r;
  wire        dw = reg_wr && reg_addr == ADDR_DATA;
  wire        iw = reg_wr && reg_addr == ADDR_IER;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow copies so the checks need no view inside the block
  always_ff @(posedge clk)
    if (!rst_n) {dl_r, sp_r} <= '0;
    else if (reg_wr && reg_addr == ADDR_LCTL) dl_r <= reg_wdata[LCTL_DIV_BIT];
    else if (reg_wr && reg_addr == ADDR_SCR) sp_r <= reg_wdata;
  sequence ier_off;
    iw && !dl_r && !reg_wdata[IER_MS_BIT] ##1 !iw;
  endsequence
  hold_pulse_a: assert property (dw && !dl_r |=> holding_wr)
    else $error("holding write missed");
  hold_quiet_a: assert property (!(dw && !dl_r) |=> !holding_wr)
    else $error("stray holding write");
  div_low_a: assert property (dw && dl_r |=> divisor[7:0] == $past(reg_wdata))
    else $error("divisor low wrong");
  div_high_a: assert property (iw && dl_r |=> divisor[15:8] == $past(reg_wdata))
    else $error("divisor high wrong");
  loop_set_a: assert property (reg_wr && reg_addr == ADDR_MCTL |=>
    loopback == $past(reg_wdata[MCTL_LOOP_BIT])) else $error("loopback wrong");
  scr_read_a: assert property (reg_addr == ADDR_SCR |=> reg_rdata == $past(sp_r))
    else $error("scratch wrong");
  irq_mask_a: assert property (ier_off |=> !modem_irq)
    else $error("irq not masked");
  txf_busy_a: assert property (fifo_mode && !txf_empty && $past(fifo_mode && !txf_empty)
    && reg_addr == ADDR_LSTAT |=> !reg_rdata[5]) else $error("empty flag wrong");
endmodule
bind ulms_core ulms_core_props u_props (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .fifo_mode, .txf_empty, .holding_wr, .modem_irq, .divisor, .loopback);

// file: verification/test_ulms_core.sv
// testbench for the line and modem status block
`timescale 1ns/1ps
module test_ulms_core;
  import ulms_pkg::*;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fifo_mode = 0, shift_load = 0;
  logic        shifter_busy = 0, txf_empty = 1, rxf_push = 0, rxf_pop = 0, rxf_clear = 0;
  logic [2:0]  reg_addr = 0, rxf_push_tags = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, got;
  logic [3:0]  lvl = 0;
  logic        cts_n, dsr_n, ring_n, cd_n, holding_wr, modem_irq, loopback;
  logic [15:0] divisor;
  int          num_errors = 0, compares = 0;
  always #12.5 clk = ~clk;
  ulms_modem u_ulms_modem (.lvl, .cts_n, .dsr_n, .ring_n, .cd_n);
  ulms_core u_ulms_core (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .fifo_mode, .shift_load, .shifter_busy, .txf_empty, .rxf_push, .rxf_push_tags, .rxf_pop,
    .rxf_clear, .cts_n, .dsr_n, .ring_n, .cd_n, .holding_wr, .modem_irq, .divisor,
    .loopback);
  task automatic stop_test;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk) reg_wr = 0;
  endtask
  task automatic ck(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk) reg_rd = 0;
    got = reg_rdata;
    chk(got, e);
  endtask
  task automatic push(input logic [2:0] t);
    @(negedge clk) {rxf_push_tags, rxf_push} = {t, 1'b1};
    @(negedge clk) rxf_push = 0;
  endtask
  task automatic pop;
    @(negedge clk) rxf_pop = 1;
    @(negedge clk) rxf_pop = 0;
  endtask
  task automatic pins(input logic [3:0] v);
    lvl = v;
    repeat (8) @(negedge clk);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    ck(ADDR_MSTAT, 8'h00);
    ck(ADDR_LSTAT, 8'h60);
    wr(ADDR_SCR, 8'hA5);
    ck(ADDR_SCR, 8'hA5);
    wr(ADDR_LCTL, 8'h80);
    wr(ADDR_DATA, 8'h34);
    chk(holding_wr, 1'b0);
    wr(ADDR_IER, 8'h12);
    chk(divisor, 16'h1234);
    ck(ADDR_IER, 8'h12);
    wr(ADDR_LCTL, 8'h00);
    wr(ADDR_DATA, 8'h55);
    chk(holding_wr, 1'b1);
    ck(ADDR_LSTAT, 8'h00);
    shifter_busy = 1;
    @(negedge clk) shift_load = 1;
    @(negedge clk) shift_load = 0;
    ck(ADDR_LSTAT, 8'h20);
    {fifo_mode, txf_empty, shifter_busy} = 3'h4;
    ck(ADDR_LSTAT, 8'h00);
    {txf_empty, shifter_busy} = 2'h3;
    ck(ADDR_LSTAT, 8'h20);
    {fifo_mode, shifter_busy} = 0;
    ck(ADDR_LSTAT, 8'h60);
    push(3'h0);
    for (int i = 0; i < 3; i++) push(3'h1 << i);
    ck(ADDR_LSTAT, 8'hE0);
    repeat (3) pop;
    ck(ADDR_LSTAT, 8'hE0);
    pop;
    ck(ADDR_LSTAT, 8'h60);
    push(3'h4);
    ck(ADDR_LSTAT, 8'hE0);
    @(negedge clk) rxf_clear = 1;
    @(negedge clk) rxf_clear = 0;
    ck(ADDR_LSTAT, 8'h60);
    wr(ADDR_IER, 8'h08);
    pins(4'h1);
    chk(modem_irq, 1'b1);
    ck(ADDR_MSTAT, 8'h11);
    ck(ADDR_MSTAT, 8'h10);
    chk(modem_irq, 1'b0);
    pins(4'h5);
    ck(ADDR_MSTAT, 8'h50);
    pins(4'hB);
    ck(ADDR_MSTAT, 8'hBE);
    pins(4'h0);
    ck(ADDR_MSTAT, 8'h0B);
    wr(ADDR_MCTL, 8'h16);
    chk(loopback, 1'b1);
    pins(4'hF);
    ck(ADDR_MSTAT, 8'h50);
    stop_test;
  end
  initial
  begin
    #20000;
    num_errors++;
    stop_test;
  end
endmodule
